// ### logic/lldd_core.sv
// Command decoder, burst engine and bank array of the low latency DDR DRAM.
`timescale 1ns/100ps
`default_nettype none
module lldd_core #(
   parameter int DATA_W = lldd_pkg::DATA_W_DEF,
   parameter int ROW_W = lldd_pkg::ROW_W_DEF,
   parameter int COL_W = lldd_pkg::COL_W_DEF,
   parameter int RD_LAT = lldd_pkg::RD_LAT_DEF,
   parameter int WR_LAT = lldd_pkg::WR_LAT_DEF,
   parameter int BANK_BUSY = lldd_pkg::BANK_BUSY_DEF
) (
   // Sampling clock and reset.
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Command side.
   input wire logic cmd_clk_i,
   input wire lldd_pkg::lldd_cmd_t cmd_i,
   // Write side.
   input wire logic write_data_clock_i,
   input wire logic write_byte_mask_i,
   // Two-way data pins.
   input wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   // Read side.
   output logic read_data_clock_o,
   output logic read_valid_flag_o,
   // Termination of unused pins.
   output logic unused_io_pin_term_o,
   // Refresh observation.
   output logic [lldd_pkg::BANK_W-1:0] refresh_bank_o,
   output logic [ROW_W-1:0] refresh_row_o
);
   import lldd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   localparam int WIDX_W = COL_W + 1;
   localparam int MA_W = BANK_W + ROW_W + WIDX_W;
   localparam int MEM_D = 2 ** MA_W;
   localparam int CW = $bits(lldd_cmd_t) + 1;
   localparam int WW = DATA_W + 2;

   typedef enum logic [2:0] {ST_IDLE, ST_RD_WAIT, ST_RD_BURST, ST_WR_WAIT, ST_WR_BURST} lldd_state_t;

   function automatic logic [MA_W-1:0] mem_idx(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
                                               input logic [WIDX_W-1:0] w);
      return {b, r, w};
   endfunction

   function automatic logic [WIDX_W-1:0] burst_start(input logic [COL_W-1:0] col, input logic [1:0] code);
      logic [WIDX_W-1:0] w;
      w = {col, 1'b0};
      if (code == BURST_CODE_4) begin
         w[1] = 1'b0;
      end else if (code == BURST_CODE_8) begin
         w[2:1] = 2'b00;
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [CW-1:0] cmd_s;
   logic ck_rise;
   logic ck_fall;
   logic [WW-1:0] wr_s;
   logic wk_rise;
   logic wk_fall;

   lldd_edge_sync #(.WIDTH(CW)) u_cmd_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .async_i({cmd_i, cmd_clk_i}),
      .sync_o(cmd_s),
      .rise_o(ck_rise),
      .fall_o(ck_fall)
   );

   lldd_edge_sync #(.WIDTH(WW)) u_wr_sync (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .async_i({write_byte_mask_i, dq_i, write_data_clock_i}),
      .sync_o(wr_s),
      .rise_o(wk_rise),
      .fall_o(wk_fall)
   );

   ////////////////////////////////////////////////////////////////////////////
   lldd_state_t state;
   lldd_mode_t mode;
   logic [BEAT_W-1:0] lat_cnt;
   logic [BEAT_W-1:0] beat;
   logic [BEAT_W-1:0] burst_n;
   logic [BANK_W-1:0] acc_bank;
   logic [ROW_W-1:0] acc_row;
   logic [WIDX_W-1:0] acc_start;
   logic [BUSY_W-1:0] busy [BANKS];
   logic [ROW_W-1:0] ref_row [BANKS];
   logic [DATA_W-1:0] mem [MEM_D];

   lldd_cmd_t cmd;
   logic [1:0] op;
   logic bank_free;
   logic cmd_take;
   logic ck_edge;
   logic wk_take;
   logic [DATA_W-1:0] wr_dq;
   logic wr_mask;
   logic [WIDX_W-1:0] beat_idx;
   logic [DATA_W-1:0] rd_word;

   assign cmd = cmd_s[CW-1:1];
   assign op = {cmd.we_n, cmd.ref_n};
   assign bank_free = (busy[cmd.bank] == '0);
   // Commands count only on a command clock rise with select low.
   // A busy bank refuses access while the other banks stay open.
   assign cmd_take = ck_rise && !cmd.cs_n && (state == ST_IDLE) && (op == OP_MRS || bank_free);
   assign ck_edge = ck_rise | ck_fall;
   // The first write word waits for a rising edge, the rest take either edge.
   assign wk_take = (beat == '0) ? wk_rise : (wk_rise | wk_fall);
   assign wr_dq = wr_s[DATA_W:1];
   assign wr_mask = wr_s[DATA_W+1];
   assign beat_idx = acc_start + WIDX_W'(beat);
   assign rd_word = mem[mem_idx(acc_bank, acc_row, beat_idx)];

   ////////////////////////////////////////////////////////////////////////////
   // Mode register; a reserved burst code leaves the old burst size in place.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         mode <= MODE_RST;
      end else if (cmd_take && op == OP_MRS) begin
         if (cmd.addr[MR_BURST_LSB +: 2] != BURST_CODE_BAD) begin
            mode.burst_size <= cmd.addr[MR_BURST_LSB +: 2];
         end
         mode.internal_termination <= cmd.addr[MR_TERM_BIT];
      end
   end

   // Bank occupancy and internal refresh row counters.
   always_ff @(posedge ref_clk_i) begin
      for (int b = 0; b < BANKS; b++) begin
         if (srst_i) begin
            busy[b] <= '0;
            ref_row[b] <= '0;
         end else begin
            if (cmd_take && op != OP_MRS && cmd.bank == BANK_W'(b)) begin
               busy[b] <= BUSY_W'(BANK_BUSY);
            end else if (ck_rise && busy[b] != '0) begin
               busy[b] <= busy[b] - 1'b1;
            end
            if (cmd_take && op == OP_AREF && cmd.bank == BANK_W'(b)) begin
               ref_row[b] <= ref_row[b] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         refresh_bank_o <= '0;
         refresh_row_o <= '0;
      end else if (cmd_take && op == OP_AREF) begin
         refresh_bank_o <= cmd.bank;
         refresh_row_o <= ref_row[cmd.bank];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burst engine. Only one burst is in flight; commands during it are dropped.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
         lat_cnt <= '0;
         beat <= '0;
         burst_n <= burst_words(BURST_CODE_2);
         acc_bank <= '0;
         acc_row <= '0;
         acc_start <= '0;
         dq_o <= '0;
         dq_oe_o <= 1'b0;
         read_valid_flag_o <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               lat_cnt <= '0;
               beat <= '0;
               if (cmd_take && (op == OP_READ || op == OP_WRITE)) begin
                  acc_bank <= cmd.bank;
                  acc_row <= cmd.addr[COL_W +: ROW_W];
                  acc_start <= burst_start(cmd.addr[COL_W-1:0], mode.burst_size);
                  burst_n <= burst_words(mode.burst_size);
                  state <= (op == OP_READ) ? ST_RD_WAIT : ST_WR_WAIT;
               end
            end
            ST_RD_WAIT: begin
               if (ck_rise) begin
                  lat_cnt <= lat_cnt + 1'b1;
                  if (lat_cnt == BEAT_W'(RD_LAT - 1)) begin
                     dq_o <= rd_word;
                     dq_oe_o <= 1'b1;
                     read_valid_flag_o <= 1'b1;
                     beat <= beat + 1'b1;
                     state <= ST_RD_BURST;
                  end
               end
            end
            ST_RD_BURST: begin
               // One word per command clock edge, two per cycle.
               if (ck_edge) begin
                  if (beat == burst_n) begin
                     dq_oe_o <= 1'b0;
                     read_valid_flag_o <= 1'b0;
                     state <= ST_IDLE;
                  end else begin
                     dq_o <= rd_word;
                     beat <= beat + 1'b1;
                  end
               end
            end
            ST_WR_WAIT: begin
               if (ck_rise) begin
                  lat_cnt <= lat_cnt + 1'b1;
                  if (lat_cnt == BEAT_W'(WR_LAT - 1)) begin
                     state <= ST_WR_BURST;
                  end
               end
            end
            ST_WR_BURST: begin
               if (wk_take) begin
                  beat <= beat + 1'b1;
                  if (beat == burst_n - 1'b1) begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // The array has no reset; its contents are undefined until written.
   always_ff @(posedge ref_clk_i) begin
      if (state == ST_WR_BURST && wk_take && !wr_mask) begin
         mem[mem_idx(acc_bank, acc_row, beat_idx)] <= wr_dq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // The read clock is the sampled command clock, registered in the same edge as
   // the data, so every word change lines up with a read clock edge.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         read_data_clock_o <= 1'b0;
         unused_io_pin_term_o <= 1'b0;
      end else begin
         read_data_clock_o <= cmd_s[0];
         unused_io_pin_term_o <= mode.internal_termination;
      end
   end

endmodule
`default_nettype wire

// ### logic/lldd_pkg.sv
// Shared constants, carriers and helpers of the low latency DDR DRAM core.
package lldd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int BANKS = 8;
   localparam int BANK_W = 3;
   localparam int ADDR_W = 21;
   localparam int BUSY_W = 4;
   localparam int BEAT_W = 4;

   // Module parameter defaults.
   localparam int DATA_W_DEF = 9;
   localparam int ROW_W_DEF = 4;
   localparam int COL_W_DEF = 3;
   localparam int RD_LAT_DEF = 3;
   localparam int WR_LAT_DEF = 4;
   localparam int BANK_BUSY_DEF = 2;

   // Command codes on {we_n, ref_n} while select is low.
   localparam logic [1:0] OP_MRS = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_AREF = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;

   // Mode register fields on the address inputs.
   localparam int MR_BURST_LSB = 3;
   localparam int MR_TERM_BIT = 9;
   localparam logic [1:0] BURST_CODE_2 = 2'h0;
   localparam logic [1:0] BURST_CODE_4 = 2'h1;
   localparam logic [1:0] BURST_CODE_8 = 2'h2;
   localparam logic [1:0] BURST_CODE_BAD = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic cs_n;
      logic we_n;
      logic ref_n;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
   } lldd_cmd_t;

   typedef struct packed {
      logic [1:0] burst_size;
      logic internal_termination;
   } lldd_mode_t;

   localparam lldd_mode_t MODE_RST = '{burst_size: BURST_CODE_2, internal_termination: 1'b0};

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [BEAT_W-1:0] burst_words(input logic [1:0] code);
      logic [BEAT_W-1:0] n;
      n = 4'h2;
      if (code == BURST_CODE_4) begin
         n = 4'h4;
      end else if (code == BURST_CODE_8) begin
         n = 4'h8;
      end
      return n;
   endfunction

endpackage

// ### logic/lldd_edge_sync.sv
// Two-stage synchroniser with edge detection on bit zero.
`timescale 1ns/100ps
`default_nettype none
module lldd_edge_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Asynchronous bundle, bit zero is a clock.
   input wire logic [WIDTH-1:0] async_i,
   // Synchronised bundle and edges of bit zero.
   output logic [WIDTH-1:0] sync_o,
   output logic rise_o,
   output logic fall_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic prev;
   logic [1:0] fill;

   // The whole bundle shares one delay, so data stays aligned to its clock.
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         stage1 <= '0;
         stage2 <= '0;
         prev <= 1'b0;
         fill <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         prev <= stage2[0];
         if (!(&fill)) begin
            fill <= fill + 2'h1;
         end
      end
   end

   // Edges are held off until prev holds a real pin sample, so a clock that idles
   // high at reset release does not fake a rise; an edge in that gap is lost.
   assign sync_o = stage2;
   assign rise_o = stage2[0] & ~prev & (&fill);
   assign fall_o = ~stage2[0] & prev & (&fill);

endmodule
`default_nettype wire

// ### dv/lldd_core_assertions.sv
// Port checks of the DRAM core, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module lldd_core_assertions #(
   parameter int DATA_W = lldd_pkg::DATA_W_DEF,
   parameter int ROW_W = lldd_pkg::ROW_W_DEF,
   parameter int RD_LAT = lldd_pkg::RD_LAT_DEF,
   parameter int LINK_HALF = 4
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // Command side.
   input wire logic cmd_clk_i,
   input wire lldd_pkg::lldd_cmd_t cmd_i,
   // Observed outputs.
   input wire logic [DATA_W-1:0] dq_o,
   input wire logic dq_oe_o,
   input wire logic read_data_clock_o,
   input wire logic read_valid_flag_o,
   input wire logic unused_io_pin_term_o,
   input wire logic [lldd_pkg::BANK_W-1:0] refresh_bank_o,
   input wire logic [ROW_W-1:0] refresh_row_o
);
   import lldd_pkg::*;
   // The past depth spans the sync stages and RD_LAT link periods.
   localparam int RD_PAST = 2 * LINK_HALF * RD_LAT + 3;
   logic [3:0] words;
   logic prev_clk;
   logic [2:0] age;
   wire logic is_mrs = !cmd_i.cs_n && {cmd_i.we_n, cmd_i.ref_n} == OP_MRS;
   wire logic is_aref = !cmd_i.cs_n && {cmd_i.we_n, cmd_i.ref_n} == OP_AREF;
   wire logic is_read = !cmd_i.cs_n && {cmd_i.we_n, cmd_i.ref_n} == OP_READ;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         words <= 4'h0;
         prev_clk <= 1'b0;
         age <= 3'h0;
      end else begin
         prev_clk <= read_data_clock_o;
         age <= (age == 3'h7) ? age : age + 3'h1;
         words <= !read_valid_flag_o ? 4'h0 : words + 4'(read_data_clock_o != prev_clk);
      end
   end
   sequence s_word_start;
      $rose(read_valid_flag_o) && $rose(read_data_clock_o);
   endsequence
   ////////////////////////////////////////////////////////////
   chk_oe_valid: assert property (dq_oe_o == read_valid_flag_o)
      else $error("data enable and valid flag differ");
   chk_rdclk_copy: assert property (age == 3'h7 |-> read_data_clock_o == $past(cmd_clk_i, 3))
      else $error("read clock does not follow command clock");
   chk_word_edges: assert property (!$stable(dq_o) |-> !$stable(read_data_clock_o))
      else $error("read word changed off a read clock edge");
   chk_burst_start: assert property ($rose(read_valid_flag_o) |-> s_word_start)
      else $error("first word not on read clock rise");
   chk_burst_len: assert property ($fell(read_valid_flag_o) |-> words inside {4'h2, 4'h4, 4'h8})
      else $error("burst word count illegal");
   chk_read_lat: assert property ($rose(read_valid_flag_o) |-> $past(is_read, RD_PAST))
      else $error("read burst without read command at latency");
   chk_term_mrs: assert property ($changed(unused_io_pin_term_o) |->
      $past(is_mrs, 4) && $past(cmd_i.addr[MR_TERM_BIT], 4) == unused_io_pin_term_o)
      else $error("termination changed without mode set");
   chk_refresh_cmd: assert property ($changed({refresh_bank_o, refresh_row_o}) |->
      $past(is_aref, 4) && refresh_bank_o == $past(cmd_i.bank, 4))
      else $error("refresh report without refresh command");
endmodule
bind lldd_core lldd_core_assertions #(.DATA_W(DATA_W), .ROW_W(ROW_W), .RD_LAT(RD_LAT)) chk_u (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_clk_i(cmd_clk_i), .cmd_i(cmd_i), .dq_o(dq_o),
   .dq_oe_o(dq_oe_o), .read_data_clock_o(read_data_clock_o), .read_valid_flag_o(read_valid_flag_o),
   .unused_io_pin_term_o(unused_io_pin_term_o), .refresh_bank_o(refresh_bank_o), .refresh_row_o(refresh_row_o));
`default_nettype wire

// ### dv/lldd_ctrl_model.sv
// Controller model driving command clock, commands, write clock and write words.
`timescale 1ns/100ps
`default_nettype none
module lldd_ctrl_model (
   // Sampling clock.
   input wire logic ref_clk_i,
   // Link side.
   output var logic cmd_clk_o,
   output var lldd_pkg::lldd_cmd_t cmd_o,
   output var logic wclk_o,
   output var logic [lldd_pkg::DATA_W_DEF-1:0] dq_o,
   output var logic mask_o
);
   import lldd_pkg::*;
   logic [2:0] ph = 3'h0;
   initial begin
      cmd_clk_o = 1'b0;
      wclk_o = 1'b1;
      cmd_o = '1;
      {dq_o, mask_o} = '0;
   end
   // Write clock lags a quarter period, so words change midway between its edges.
   always @(posedge ref_clk_i) begin
      #1;
      ph = ph + 3'h1;
      cmd_clk_o = ph[2];
      wclk_o = ~(ph[2] ^ ph[1]);
   end
   task automatic issue(input logic [1:0] op, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a);
      @(negedge cmd_clk_o);
      cmd_o = '{cs_n: 1'b0, we_n: op[1], ref_n: op[0], bank: b, addr: a};
   endtask
   // Released lines show the inverse of the last value; select ends high.
   task automatic rel();
      @(negedge cmd_clk_o);
      cmd_o = ~cmd_o;
   endtask
   task automatic wr(input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a, input int n,
                     input logic [8*DATA_W_DEF-1:0] w, input logic [7:0] m);
      issue(OP_WRITE, b, a);
      rel();
      repeat (WR_LAT_DEF) @(posedge cmd_clk_o);
      for (int i = 0; i < n; i++) begin
         if (i > 0) @(cmd_clk_o);
         {dq_o, mask_o} = {w[i*DATA_W_DEF +: DATA_W_DEF], m[i]};
      end
      @(cmd_clk_o);
      {dq_o, mask_o} = ~{dq_o, mask_o};
   endtask
endmodule
`default_nettype wire

// ### dv/lldd_core_tb_top.sv
// Self-checking bench of the DRAM core with a controller model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin errors++; \
   $display("mismatch %s %h %h", nm, e, s); end end
module lldd_core_tb_top;
   import lldd_pkg::*;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic cmd_clk, wclk, mask, oe, rdclk, valid, term;
   lldd_cmd_t cmd;
   logic [8:0] dq_w, dq_r, got_e;
   logic [2:0] rbank;
   logic [3:0] rrow;
   int errors = 0;
   int n_compared = 0;
   logic [8:0] exp_q[$];
   logic [31:0] rs = 32'h0000_8846;
   logic prev_clk = 1'b0;
   wire logic [8:0] dq_pin = oe ? dq_r : dq_w;
   always #20 ref_clk_i = ~ref_clk_i;
   lldd_ctrl_model ctrl_u (.ref_clk_i(ref_clk_i), .cmd_clk_o(cmd_clk), .cmd_o(cmd), .wclk_o(wclk), .dq_o(dq_w),
      .mask_o(mask));
   lldd_core dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .cmd_clk_i(cmd_clk), .cmd_i(cmd), .write_data_clock_i(wclk),
      .write_byte_mask_i(mask), .dq_i(dq_pin), .dq_o(dq_r), .dq_oe_o(oe), .read_data_clock_o(rdclk),
      .read_valid_flag_o(valid), .unused_io_pin_term_o(term), .refresh_bank_o(rbank), .refresh_row_o(rrow));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   ////////////////////////////////////////////////////////////
   // Each read clock edge under the valid flag carries one word.
   always @(negedge ref_clk_i) begin
      if (valid === 1'b1 && rdclk !== prev_clk) begin
         if (exp_q.size() == 0) `CHK("spare word", 1'b0, 1'b1)
         else begin
            got_e = exp_q.pop_front();
            `CHK("read word", got_e, dq_r)
         end
      end
      prev_clk = rdclk;
   end
   task automatic wrap_up();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // The extra wait lets the engine go idle and the bank timer run out.
   task automatic drain();
      int k;
      k = 0;
      while (exp_q.size() != 0 && k < 400) begin
         @(posedge ref_clk_i);
         k++;
      end
      if (k == 400) begin
         errors++;
         wrap_up();
      end
      repeat (24) @(posedge ref_clk_i);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      logic [95:0] a, b;
      logic [7:0] m;
      logic [20:0] ad;
      int n;
      repeat (6) @(posedge ref_clk_i);
      #1 srst_i = 1'b0;
      // Burst codes 2, 4, 8, then the spare code, which keeps 8.
      for (int c = 0; c < 4; c++) begin
         n = (c == 3) ? 8 : 2 << c;
         rs = xs(rs);
         ad = rs[20:0];
         a = {3{rs}};
         rs = xs(rs);
         b = {3{rs}};
         m = rs[7:0];
         ctrl_u.issue(OP_MRS, 3'h0, 21'({c[0], 4'h0, c[1:0], 3'h0}));
         ctrl_u.rel();
         repeat (8) @(posedge ref_clk_i);
         `CHK("term", c[0], term)
         ctrl_u.wr(c[2:0], ad, n, a[71:0], 8'h00);
         drain();
         ctrl_u.wr(c[2:0], ad, n, b[71:0], m);
         drain();
         for (int i = 0; i < n; i++) exp_q.push_back(m[i] ? a[i*9 +: 9] : b[i*9 +: 9]);
         ctrl_u.issue(OP_READ, c[2:0], ad ^ 21'(n / 2 - 1));
         ctrl_u.rel();
         drain();
      end
      // The second refresh hits a busy bank and is dropped; another bank overlaps.
      ctrl_u.issue(OP_AREF, 3'h6, 21'h0);
      ctrl_u.issue(OP_AREF, 3'h6, 21'h0);
      ctrl_u.issue(OP_AREF, 3'h1, 21'h0);
      ctrl_u.rel();
      drain();
      `CHK("refresh bank", 3'h1, rbank)
      `CHK("refresh row", 4'h0, rrow)
      ctrl_u.issue(OP_AREF, 3'h6, 21'h0);
      ctrl_u.rel();
      drain();
      `CHK("refresh row", 4'h1, rrow)
      wrap_up();
   end
endmodule
`default_nettype wire
